// [hw/timer8_divider.sv]
// Pre-scaler and scaler producing the divided timer clock enable.
`timescale 1ns/1ns
`include "timer8_defs.svh"
module timer8_divider
    import timer8_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic rst_b,
    tick_if.divider   tk
);
    div_state_s s_q;
    div_state_s s_d;
    logic [5:0] pre_last;
    logic       pre_done;
    logic       scl_done;

    always_comb begin
        case (tk.pre_sel)
            2'h0:    pre_last = `T8_PRE_LAST_1;
            2'h1:    pre_last = `T8_PRE_LAST_4;
            2'h2:    pre_last = `T8_PRE_LAST_16;
            default: pre_last = `T8_PRE_LAST_64;
        endcase
        // Compare with >= so a smaller setting written mid-count wraps at once.
        pre_done = tk.src_tick && (s_q.pre_cnt >= pre_last); // R2
        scl_done = pre_done && (s_q.scl_cnt >= tk.scale); // R3
        tk.div_tick = scl_done;
        s_d = s_q;
        if (tk.src_tick) begin
            s_d.pre_cnt = pre_done ? 6'h00 : s_q.pre_cnt + 6'h01;
        end
        if (pre_done) begin
            s_d.scl_cnt = scl_done ? 5'h00 : s_q.scl_cnt + 5'h01;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    a_div_needs_src : assert property (@(posedge core_clk) disable iff (!rst_b) // R2
        tk.div_tick |-> tk.src_tick && s_q.pre_cnt >= pre_last)
        else $error("divided tick without a pre-scaler terminal count");

endmodule : timer8_divider

// [hw/timer8_period_pwm.sv]
// 8-bit up-counting timer with period and PWM waveform output.
// Functional notes
// R1 - Period mode gives 50% square wave
// R2 - Pre-scaler divides by 1, 4, 16, 64
// R3 - Scaler divides further by value plus one
// R4 - Control high nibble selects the input clock
// R5 - Full bound value is the compare limit
// R6 - 8-bit PWM: 256 ticks, high bound+1
// R7 - 6-bit PWM: 64 ticks, high bound+1
// R8 - Timer event sets flag regardless of enable
// R9 - Only a software write clears the flag
// R10 - Counter counts up, clears at bound
// R11 - Routing field forces waveform onto a pin
// R12 - Counter value is writable and readable
// R13 - Mode bit clear means period mode
//
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/1ns
`include "timer8_defs.svh"
module timer8_period_pwm
    import timer8_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst_b,
    input  wire logic [2:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       src_hrc,
    input  wire logic       src_lrc,
    input  wire logic       src_pa0,
    input  wire logic       src_pa4,
    output logic            wave_out_pin_a,
    output logic            wave_out_pin_a_oe,
    output logic            wave_out_pin_b,
    output logic            wave_out_pin_b_oe,
    output logic            irq
);
    timer_state_s s_q;
    timer_state_s s_d;
    tick_if       tk ();
    mode_e        mode;
    logic [3:0]   rise;
    logic [3:0]   fall;
    logic         src_tick;
    logic         hit;
    logic         event_hit;
    logic         clr_hit;
    logic [1:0]   route;

    timer8_divider u_div (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .tk       (tk.divider)
    );

    // =======================================================================
    // Clock source selection
    // Pin sources are sampled, so each is usable only well below core_clk/2.
    always_comb begin
        rise = s_q.sync2 & ~s_q.prev;
        fall = ~s_q.sync2 & s_q.prev;
        case (s_q.control[`T8_CTL_SRC_HI:`T8_CTL_SRC_LO]) // R4
            `T8_SRC_SYS:      src_tick = 1'b1;
            `T8_SRC_HRC:      src_tick = rise[0];
            `T8_SRC_LRC:      src_tick = rise[1];
            `T8_SRC_PA0_RISE: src_tick = rise[2];
            `T8_SRC_PA0_FALL: src_tick = fall[2];
            `T8_SRC_PA4_RISE: src_tick = rise[3];
            `T8_SRC_PA4_FALL: src_tick = fall[3];
            default:          src_tick = 1'b0;
        endcase
    end

    assign tk.src_tick = src_tick;
    assign tk.pre_sel  = s_q.scaler[`T8_SCL_PRE_HI:`T8_SCL_PRE_LO];
    assign tk.scale    = s_q.scaler[`T8_SCL_DIV_HI:`T8_SCL_DIV_LO];

    // =======================================================================
    // Mode decode
    // The resolution bit only matters once the mode bit selects PWM.
    always_comb begin
        if (!s_q.control[`T8_CTL_MODE]) begin
            mode = MODE_PERIOD; // R13
        end else if (s_q.scaler[`T8_SCL_RES]) begin
            mode = MODE_PWM6;
        end else begin
            mode = MODE_PWM8;
        end
    end

    // =======================================================================
    // Next state
    always_comb begin
        s_d       = s_q;
        s_d.sync1 = {src_pa4, src_pa0, src_lrc, src_hrc};
        s_d.sync2 = s_q.sync1;
        s_d.prev  = s_q.sync2;
        hit       = (s_q.count == s_q.bound); // R5
        event_hit = tk.div_tick && hit;
        clr_hit   = reg_wr && (reg_addr == `T8_OFS_STATUS) && reg_wdata[`T8_IRQ_TIMER];
        if (tk.div_tick) begin
            case (mode)
                MODE_PERIOD: begin
                    if (hit) begin
                        s_d.count = 8'h00; // R10
                        s_d.wave  = ~s_q.wave; // R1
                    end else begin
                        s_d.count = s_q.count + 8'h01; // R10
                    end
                end
                MODE_PWM6: begin
                    // Upper bits forced low so a count left above 63 falls back in range.
                    s_d.count = {2'h0, s_q.count[5:0] + 6'h01}; // R7
                end
                MODE_PWM8: begin
                    s_d.count = s_q.count + 8'h01; // R6
                end
                default: begin
                    s_d.count = 8'h00;
                end
            endcase
        end
        if (reg_wr) begin
            case (reg_addr)
                `T8_OFS_CONTROL: s_d.control = reg_wdata;
                `T8_OFS_COUNT:   s_d.count   = reg_wdata; // R12
                `T8_OFS_SCALER:  s_d.scaler  = reg_wdata;
                `T8_OFS_BOUND:   s_d.bound   = reg_wdata;
                `T8_OFS_MASK:    s_d.mask    = reg_wdata[`T8_IRQ_TIMER];
                default:         s_d.mask    = s_q.mask;
            endcase
        end
        // A new event wins over a clear in the same cycle.
        s_d.status = (s_q.status && !clr_hit) || event_hit; // R8 R9
        if (mode != MODE_PERIOD) begin
            // High for counts 0..bound, so bound+1 ticks of each period.
            s_d.wave = (s_d.count <= s_d.bound); // R6 R7
        end
        // Read data is zero outside the answer cycle, so slaves can be OR-ed together.
        s_d.rdata = `T8_RST_REG;
        if (reg_rd) begin
            case (reg_addr)
                `T8_OFS_CONTROL: s_d.rdata = s_q.control;
                `T8_OFS_COUNT:   s_d.rdata = s_q.count; // R12
                `T8_OFS_SCALER:  s_d.rdata = s_q.scaler;
                `T8_OFS_BOUND:   s_d.rdata = s_q.bound;
                `T8_OFS_STATUS:  s_d.rdata = {7'h00, s_q.status};
                `T8_OFS_MASK:    s_d.rdata = {7'h00, s_q.mask};
                default:         s_d.rdata = `T8_RST_REG;
            endcase
        end
        route     = s_d.control[`T8_CTL_OUT_HI:`T8_CTL_OUT_LO];
        s_d.pin_a = s_d.wave && (route == `T8_ROUTE_PIN_A); // R11
        s_d.pin_b = s_d.wave && (route == `T8_ROUTE_PIN_B); // R11
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // =======================================================================
    // Outputs
    // The routed pin is driven whatever the port direction setting says.
    assign wave_out_pin_a_oe = (s_q.control[`T8_CTL_OUT_HI:`T8_CTL_OUT_LO] == `T8_ROUTE_PIN_A);
    assign wave_out_pin_b_oe = (s_q.control[`T8_CTL_OUT_HI:`T8_CTL_OUT_LO] == `T8_ROUTE_PIN_B);
    assign wave_out_pin_a    = s_q.pin_a;
    assign wave_out_pin_b    = s_q.pin_b;
    assign reg_rdata         = s_q.rdata;
    assign irq               = s_q.status && s_q.mask;

    // =======================================================================
    // Checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    sequence seq_period_tick;
        tk.div_tick && mode == MODE_PERIOD && !reg_wr;
    endsequence

    sequence seq_period_wrap;
        seq_period_tick ##0 hit;
    endsequence

    a_flag_sets : assert property (event_hit |=> s_q.status) // R8
        else $error("timer event did not set the request flag");

    a_flag_holds : assert property ( // R9
        s_q.status && !clr_hit |=> s_q.status)
        else $error("request flag dropped without a software clear");

    a_period_wrap : assert property ( // R10
        seq_period_wrap |=> s_q.count == 8'h00)
        else $error("counter did not clear at the bound");

    a_count_up : assert property ( // R10
        seq_period_tick ##0 !hit |=> s_q.count == $past(s_q.count) + 8'h01)
        else $error("counter did not step up by one");

    a_wave_toggle : assert property ( // R1
        seq_period_wrap |=> s_q.wave != $past(s_q.wave))
        else $error("period waveform did not toggle at the bound");

    a_wave_still : assert property ( // R1
        seq_period_tick ##0 !hit |=> s_q.wave == $past(s_q.wave))
        else $error("period waveform changed before the bound");

    a_pwm_duty : assert property ( // R6
        s_q.control[`T8_CTL_MODE] && !reg_wr |=> s_q.wave == (s_q.count <= s_q.bound))
        else $error("pwm level does not match count against bound");

    a_pwm8_wrap : assert property ( // R6
        tk.div_tick && mode == MODE_PWM8 && s_q.count == `T8_PWM8_LAST && !reg_wr
        |=> s_q.count == 8'h00)
        else $error("8-bit pwm period is not 256 ticks");

    a_pwm6_wrap : assert property ( // R7
        tk.div_tick && mode == MODE_PWM6 && s_q.count == `T8_PWM6_LAST && !reg_wr
        |=> s_q.count == 8'h00)
        else $error("6-bit pwm period is not 64 ticks");

    a_count_read : assert property ( // R12
        reg_rd && reg_addr == `T8_OFS_COUNT |=> reg_rdata == $past(s_q.count))
        else $error("counter read returned a wrong value");

    a_stop_source : assert property ( // R4
        s_q.control[`T8_CTL_SRC_HI:`T8_CTL_SRC_LO] == `T8_SRC_STOP |-> !tk.div_tick)
        else $error("timer ticked with the stop source selected");

    a_pin_route : assert property ( // R11
        wave_out_pin_a_oe && !reg_wr |=> wave_out_pin_a == s_q.wave && wave_out_pin_a_oe)
        else $error("waveform not forced onto the selected pin");

    // =======================================================================
    // Register, counter, flag, pin and clock source checks
    // Four look one cycle past a tick with no bus write, since a write overrides the tick.
    sequence seq_flag_clear;
        reg_wr && reg_addr == `T8_OFS_STATUS && reg_wdata[`T8_IRQ_TIMER];
    endsequence

    sequence seq_count_write;
        reg_wr && reg_addr == `T8_OFS_COUNT;
    endsequence

    a_flag_clear : assert property ( // R9
        seq_flag_clear ##0 !event_hit |=> !s_q.status)
        else $error("request flag not cleared by a software write");

    a_flag_no_event : assert property ( // R8
        !s_q.status && !event_hit |=> !s_q.status)
        else $error("request flag set without a timer event");

    a_flag_unmasked : assert property ( // R8
        event_hit && !s_q.mask |=> s_q.status)
        else $error("request flag not set while the interrupt is masked");

    a_count_write : assert property ( // R12
        seq_count_write |=> s_q.count == $past(reg_wdata))
        else $error("counter write did not land");

    a_count_hold : assert property ( // R10
        !tk.div_tick && !reg_wr |=> s_q.count == $past(s_q.count))
        else $error("counter moved without a divided tick");

    a_pwm8_step : assert property ( // R6
        tk.div_tick && mode == MODE_PWM8 && !reg_wr |=> s_q.count == $past(s_q.count) + 8'h01)
        else $error("8-bit pwm counter did not step up");

    a_pwm6_step : assert property ( // R7
        tk.div_tick && mode == MODE_PWM6 && s_q.count < `T8_PWM6_LAST && !reg_wr
        |=> s_q.count == $past(s_q.count) + 8'h01)
        else $error("6-bit pwm counter did not step up");

    a_pwm6_range : assert property ( // R7
        tk.div_tick && mode == MODE_PWM6 && !reg_wr |=> s_q.count <= `T8_PWM6_LAST)
        else $error("6-bit pwm counter left its range");

    a_pin_b_route : assert property ( // R11
        wave_out_pin_b_oe && !reg_wr |=> wave_out_pin_b == s_q.wave && wave_out_pin_b_oe)
        else $error("waveform not forced onto the second pin");

    a_pin_a_idle : assert property ( // R11
        !wave_out_pin_a_oe && !reg_wr |=> !wave_out_pin_a)
        else $error("unrouted first pin carries the waveform");

    a_pin_b_idle : assert property ( // R11
        !wave_out_pin_b_oe && !reg_wr |=> !wave_out_pin_b)
        else $error("unrouted second pin carries the waveform");

    a_rdata_idle : assert property ( // R12
        !reg_rd |=> reg_rdata == `T8_RST_REG)
        else $error("read data present without a read");

    a_sys_source : assert property ( // R4
        s_q.control[`T8_CTL_SRC_HI:`T8_CTL_SRC_LO] == `T8_SRC_SYS |-> tk.src_tick)
        else $error("system clock source gave no tick");

    a_res_ignored : assert property ( // R13
        !s_q.control[`T8_CTL_MODE] && tk.div_tick && !hit && !reg_wr
        |=> s_q.count == $past(s_q.count) + 8'h01)
        else $error("period mode counting depends on the resolution bit");

endmodule : timer8_period_pwm

// [shared/tick_if.sv]
// Interface carrying the source tick, divider settings and divided tick.
`timescale 1ns/1ns
interface tick_if;
    logic       src_tick;
    logic [1:0] pre_sel;
    logic [4:0] scale;
    logic       div_tick;

    modport timer (output src_tick, output pre_sel, output scale, input div_tick);
    modport divider (input src_tick, input pre_sel, input scale, output div_tick);
endinterface : tick_if

// [shared/timer8_defs.svh]
// Register offsets, field positions, codes and reset values of the 8-bit timer.
`ifndef TIMER8_DEFS_SVH
`define TIMER8_DEFS_SVH

// ===========================================================================
// Register offsets
`define T8_OFS_CONTROL    3'h0
`define T8_OFS_COUNT      3'h1
`define T8_OFS_SCALER     3'h2
`define T8_OFS_BOUND      3'h3
`define T8_OFS_STATUS     3'h4
`define T8_OFS_MASK       3'h5

// ===========================================================================
// Field positions
`define T8_CTL_SRC_HI     7
`define T8_CTL_SRC_LO     4
`define T8_CTL_OUT_HI     3
`define T8_CTL_OUT_LO     2
`define T8_CTL_MODE       1
`define T8_SCL_RES        7
`define T8_SCL_PRE_HI     6
`define T8_SCL_PRE_LO     5
`define T8_SCL_DIV_HI     4
`define T8_SCL_DIV_LO     0
`define T8_IRQ_TIMER      0

// ===========================================================================
// Clock source codes
`define T8_SRC_STOP       4'h0
`define T8_SRC_SYS        4'h1
`define T8_SRC_HRC        4'h2
`define T8_SRC_LRC        4'h3
`define T8_SRC_PA0_RISE   4'h4
`define T8_SRC_PA0_FALL   4'h5
`define T8_SRC_PA4_RISE   4'h6
`define T8_SRC_PA4_FALL   4'h7

// ===========================================================================
// Output routing codes and pre-scaler and PWM terminal counts
`define T8_ROUTE_PIN_A    2'h2
`define T8_ROUTE_PIN_B    2'h3
`define T8_PRE_LAST_1     6'h00
`define T8_PRE_LAST_4     6'h03
`define T8_PRE_LAST_16    6'h0f
`define T8_PRE_LAST_64    6'h3f
`define T8_PWM6_LAST      8'h3f
`define T8_PWM8_LAST      8'hff

// ===========================================================================
// Reset values
`define T8_RST_REG        8'h00

`endif

// [shared/timer8_pkg.sv]
// Types shared by the 8-bit timer modules.
package timer8_pkg;

    typedef enum logic [1:0] {
        MODE_PERIOD,
        MODE_PWM8,
        MODE_PWM6
    } mode_e;

    typedef struct packed {
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic [3:0] prev;
        logic [7:0] control;
        logic [7:0] scaler;
        logic [7:0] bound;
        logic [7:0] count;
        logic       status;
        logic       mask;
        logic [7:0] rdata;
        logic       wave;
        logic       pin_a;
        logic       pin_b;
    } timer_state_s;

    typedef struct packed {
        logic [5:0] pre_cnt;
        logic [4:0] scl_cnt;
    } div_state_s;

endpackage : timer8_pkg

// [tb/timer8_period_pwm_tb_top.sv]
// Self-checking bench for the 8-bit period and PWM timer.
`timescale 1ns/1ns
`include "timer8_defs.svh"
module timer8_period_pwm_tb_top
    import timer8_pkg::*;
;
    logic        core_clk;
    logic        rst_b;
    logic [2:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic [3:0]  src_v;
    logic        pin_a;
    logic        pin_a_oe;
    logic        pin_b;
    logic        pin_b_oe;
    logic        irq;
    logic [15:0] hi_q;
    logic [15:0] lo_q;
    int          err_count;
    int          n_tests;
    int          cycles;

    timer8_period_pwm u_timer8_period_pwm (
        .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_hrc(src_v[0]),
        .src_lrc(src_v[1]), .src_pa0(src_v[2]), .src_pa4(src_v[3]),
        .wave_out_pin_a(pin_a), .wave_out_pin_a_oe(pin_a_oe), .wave_out_pin_b(pin_b),
        .wave_out_pin_b_oe(pin_b_oe), .irq(irq));

    wave_load u_wave_load (.core_clk(core_clk), .rst_b(rst_b), .pin(pin_a_oe ? pin_a : pin_b),
        .pin_oe(pin_a_oe | pin_b_oe), .hi_q(hi_q), .lo_q(lo_q));

    always #25 core_clk = ~core_clk;

    // ==================
    // Run limit
    // The longest wave test needs about 3100 cycles; the whole run stays near 6200.
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            stop_test();
        end
    end

    // ==================
    // Tasks
    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_len(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: run %h expected %h", $time, got, exp);
        end
    endtask : chk_len

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk_reg(reg_rdata, exp);
    endtask : rd_chk

    task automatic run_wave(input logic [7:0] ctl, input logic [7:0] scl, input logic [7:0] bnd,
                            input int n, input logic [15:0] eh, input logic [15:0] el);
        wr(`T8_OFS_SCALER, scl);
        wr(`T8_OFS_BOUND, bnd);
        wr(`T8_OFS_COUNT, 8'h00);
        wr(`T8_OFS_CONTROL, ctl);
        repeat (n) @(posedge core_clk);
        #1;
        chk_len(hi_q, eh);
        chk_len(lo_q, el);
        $display("Wave test %h %h %h done", ctl, scl, bnd);
    endtask : run_wave

    // ==================
    // Main sequence
    initial begin
        core_clk = 1'b0;
        rst_b = 1'b0;
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        src_v = 4'h0;
        err_count = 0;
        n_tests = 0;
        cycles = 0;
        repeat (6) @(posedge core_clk);
        rst_b <= 1'b1;
        for (int a = 0; a < 8; a++) rd_chk(a[2:0], 8'h00);
        wr(`T8_OFS_CONTROL, 8'ha5);
        rd_chk(`T8_OFS_CONTROL, 8'ha5);
        wr(`T8_OFS_SCALER, 8'hff);
        rd_chk(`T8_OFS_SCALER, 8'hff);
        wr(`T8_OFS_BOUND, 8'h5a);
        rd_chk(`T8_OFS_BOUND, 8'h5a);
        wr(`T8_OFS_COUNT, 8'h3c);
        rd_chk(`T8_OFS_COUNT, 8'h3c);
        wr(`T8_OFS_MASK, 8'hff);
        rd_chk(`T8_OFS_MASK, 8'h01);
        wr(3'h6, 8'hff);
        rd_chk(3'h6, 8'h00);
        wr(`T8_OFS_MASK, 8'h00);
        $display("Register test done");
        for (int p = 0; p < 4; p++) begin
            run_wave(8'h18, {1'b0, p[1:0], 5'h03}, 8'h01, 6 * (8 << (2 * p)) + 40,
                     16'(8 << (2 * p)), 16'(8 << (2 * p)));
        end
        run_wave(8'h18, 8'h80, 8'h04, 100, 16'h0005, 16'h0005);
        run_wave(8'h1a, 8'h00, 8'h09, 600, 16'h000a, 16'h00f6);
        run_wave(8'h1a, 8'h81, 8'h09, 400, 16'h0014, 16'h006c);
        run_wave(8'h1e, 8'h81, 8'h09, 400, 16'h0014, 16'h006c);
        chk_reg({6'h00, pin_a_oe, pin_b_oe}, 8'h01);
        wr(`T8_OFS_CONTROL, 8'h00);
        rd_chk(`T8_OFS_STATUS, 8'h01);
        chk_reg({7'h00, irq}, 8'h00);
        wr(`T8_OFS_STATUS, 8'hfe);
        rd_chk(`T8_OFS_STATUS, 8'h01);
        wr(`T8_OFS_MASK, 8'h01);
        #1;
        chk_reg({7'h00, irq}, 8'h01);
        wr(`T8_OFS_STATUS, 8'h01);
        rd_chk(`T8_OFS_STATUS, 8'h00);
        chk_reg({7'h00, irq}, 8'h00);
        $display("Interrupt test done");
        wr(`T8_OFS_BOUND, 8'hff);
        wr(`T8_OFS_SCALER, 8'h00);
        for (int c = 0; c < 9; c++) begin
            if (c != 1) begin
                wr(`T8_OFS_CONTROL, {c[3:0], 4'h0});
                wr(`T8_OFS_COUNT, 8'h00);
                repeat (3) begin
                    src_v[(c < 2 || c > 7) ? 0 : (c < 4) ? c - 2 : c / 2] <= 1'b1;
                    repeat (4) @(posedge core_clk);
                    src_v <= 4'h0;
                    repeat (4) @(posedge core_clk);
                end
                repeat (6) @(posedge core_clk);
                rd_chk(`T8_OFS_COUNT, (c >= 2 && c <= 7) ? 8'h03 : 8'h00);
            end
        end
        $display("Clock source test done");
        stop_test();
    end
endmodule : timer8_period_pwm_tb_top

// [tb/wave_load.sv]
// Load on the timer's waveform pin that measures the last high and low run lengths.
`timescale 1ns/1ns
module wave_load (
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic        pin,
    input  wire logic        pin_oe,
    output logic      [15:0] hi_q,
    output logic      [15:0] lo_q
);
    logic [15:0] run_q;
    logic        last_q;

    // ==================
    // Run measurement
    // An unrouted pin carries no waveform, so the current run restarts while no output drives it.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            hi_q <= 16'h0000;
            lo_q <= 16'h0000;
            run_q <= 16'h0000;
            last_q <= 1'b0;
        end else if (!pin_oe) begin
            run_q <= 16'h0000;
            last_q <= pin;
        end else if (pin != last_q) begin
            if (last_q) begin
                hi_q <= run_q;
            end else begin
                lo_q <= run_q;
            end
            run_q <= 16'h0001;
            last_q <= pin;
        end else begin
            run_q <= run_q + 16'h0001;
        end
    end
endmodule : wave_load
